// >>> hdl/bil_boot_loader.sv
// boot image loader: strap capture, host port setup, i2c and spi master image fetch,
// fetched bytes buffered in a fifo toward the device memory
// assumes clk is the 25 MHz peripheral bus clock and arst_n the power-on reset
`timescale 1ns/1ns
`include "bil_defines.svh"

// -----------------------------------------------------------------------------
// buffer between the fetch engine and the memory writer
// -----------------------------------------------------------------------------
module bil_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `BIL_FIFO_DEPTH,
  parameter int AW = `BIL_FIFO_AW
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // fill side
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  // drain side
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_ff;
  logic [AW:0] rdPtr_ff;
  logic push;
  logic pop;

  assign inReady = (wrPtr_ff - rdPtr_ff) != (AW+1)'(DEPTH);
  assign outValid = wrPtr_ff != rdPtr_ff;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr_ff[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_ff[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      if (push) begin
        wrPtr_ff <= wrPtr_ff + (AW+1)'(1);
      end
      if (pop) begin
        rdPtr_ff <= rdPtr_ff + (AW+1)'(1);
      end
    end
  end
endmodule

// Overview of operation
// - host port is 8 or 16 bits wide per the width strap after power-on
// - host strobe arrangement follows the polarity and dual strobe straps
// - straps latched only at power-on release; hard reset keeps them
// - host data bit 0 is the least significant bit
// - i2c boot switches shared pins to i2c, then reads the image
// - i2c boot keeps the pll bypassed, running from the bus clock
// - i2c boot is master and polled; the memory answers as slave
// - i2c bit clock is the bus clock divided by 128
// - i2c boot addresses the memory at slave address 0xA0
// - bus clock is input clock / 2, at most 50 MHz
// - i2c bit clock never exceeds 400 kbps
// - spi boot switches shared pins to spi, then reads the image
// - during spi boot the loader is master, driving clock and select
// - read_identification_command reply 0x00/0xFF picks eeprom at 4 Mbps max, else flash
// - main spi pin set keeps the pll permitted
// - alternate spi pin set forbids the pll
// - spi boot failures are signalled on the boot error event pin
module bil_boot_loader
  import bil_pkg::*;
(
  // clock and resets
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hardRst_n,
  // strap pins: width, strobe polarity, dual strobe, source[1:0]
  input wire logic [`BIL_STRAP_W-1:0] strapPins,
  // host parallel port setup
  output bil_host_cfg_t hostCfg,
  output logic hostBootEn,
  // shared pin function and clocking
  output bil_pinfunc_t pinFunc,
  output logic pllAllowed,
  // i2c pins, open drain: oe high pulls low
  output logic sclOut,
  output logic sclOe,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic sdaIn,
  // spi pins
  output logic spiSck,
  output logic spiCs_n,
  output logic spiMosi,
  input wire logic spiMiso,
  // image stream toward device memory
  output logic [7:0] imgData,
  output logic imgValid,
  input wire logic imgReady,
  // status
  output logic spiFlash,
  output logic bootDone,
  output logic bootErrEvent
);

  // ---------------------------------------------------------------------------
  // states
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_SEL = 4'b0001,
    ST_HOST = 4'b0010,
    ST_START = 4'b0011,
    ST_TX = 4'b0100,
    ST_RX = 4'b0101,
    ST_ACK = 4'b0110,
    ST_STOP = 4'b0111,
    ST_DONE = 4'b1000,
    ST_ERR = 4'b1001
  } bil_state_t;

  bil_state_t state_ff;
  logic [`BIL_STRAP_W-1:0] strapMeta_ff;
  logic [`BIL_STRAP_W-1:0] strapSync_ff;
  logic [2:0] inMeta_ff;
  logic [2:0] inSync_ff;
  logic strapTaken_ff;
  bil_src_t src_ff;
  bil_host_cfg_t hostCfg_ff;
  bil_pinfunc_t pinFunc_ff;
  bil_pins_t pins_ff;
  logic [5:0] qCnt_ff;
  logic [1:0] phase_ff;
  logic [2:0] bitIdx_ff;
  logic [1:0] step_ff;
  logic [7:0] shOut_ff;
  logic [7:0] shIn_ff;
  logic [15:0] rxCount_ff;
  logic idPhase_ff;
  logic isFlash_ff;
  logic errEvent_ff;
  logic done_ff;
  logic [7:0] push_ff;
  logic pushValid_ff;
  logic pushReady;
  logic hardRstSync;
  logic misoSync;
  logic sdaSync;
  logic isI2c;
  logic active;
  logic qTick;
  logic cellEnd;
  logic byteEnd;
  logic lastByte;
  logic [5:0] qLen;
  logic [7:0] rxByte;

  // ---------------------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strapMeta_ff <= '0;
      strapSync_ff <= '0;
      inMeta_ff <= 3'h7;
      inSync_ff <= 3'h7;
    end else begin
      strapMeta_ff <= strapPins;
      strapSync_ff <= strapMeta_ff;
      inMeta_ff <= {hardRst_n, spiMiso, sdaIn};
      inSync_ff <= inMeta_ff;
    end
  end

  assign hardRstSync = !inSync_ff[2];
  assign misoSync = inSync_ff[1];
  assign sdaSync = inSync_ff[0];

  // ---------------------------------------------------------------------------
  // strap capture, once per power-on reset
  // ---------------------------------------------------------------------------
  // waits until the synchronised straps have settled after the release
  logic [1:0] strapWait_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strapWait_ff <= '0;
      strapTaken_ff <= 1'b0;
      hostCfg_ff <= '0;
      src_ff <= SRC_HOST;
    end else if (!strapTaken_ff) begin
      strapWait_ff <= strapWait_ff + 2'h1;
      if (strapWait_ff == 2'h3) begin
        strapTaken_ff <= 1'b1;
        hostCfg_ff.wide16 <= strapSync_ff[`BIL_STRAP_WIDTH];
        hostCfg_ff.strobePolarity <= strapSync_ff[`BIL_STRAP_POL];
        hostCfg_ff.dualStrobe <= strapSync_ff[`BIL_STRAP_DUAL];
        src_ff <= bil_src_t'(strapSync_ff[`BIL_STRAP_SRC_HI:`BIL_STRAP_SRC_LO]);
      end
    end
  end

  // host data bit 0 is passed straight through as the lsb; no swap here
  assign hostCfg = hostCfg_ff;

  // ---------------------------------------------------------------------------
  // bit cell timing: four quarters per bit, clock high in quarters 2 and 3
  // ---------------------------------------------------------------------------
  assign isI2c = (src_ff == SRC_I2C);
  assign active = (state_ff == ST_START) || (state_ff == ST_TX) || (state_ff == ST_RX)
                  || (state_ff == ST_ACK) || (state_ff == ST_STOP);

  // 128 clocks per i2c bit gives 195 kbps at 25 MHz, well under 400 kbps
  always_comb begin
    if (isI2c) begin
      qLen = 6'(`BIL_I2C_QTR);
    end else if (isFlash_ff) begin
      qLen = 6'(`BIL_FLASH_QTR);
    end else begin
      qLen = 6'(`BIL_EEP_QTR);
    end
  end

  // a byte waiting for the fifo stalls the bit clock: back-pressure to the memory
  assign qTick = active && !pushValid_ff && (qCnt_ff == 6'h01 || qLen == 6'h01);
  assign cellEnd = qTick && (phase_ff == 2'h3);
  assign byteEnd = cellEnd && (bitIdx_ff == 3'h7);
  assign lastByte = (rxCount_ff == `BIL_IMG_BYTES - 16'h0001);
  assign rxByte = {shIn_ff[6:0], isI2c ? sdaSync : misoSync};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      qCnt_ff <= 6'h01;
      phase_ff <= 2'h0;
    end else if (!active || hardRstSync) begin
      qCnt_ff <= 6'h01;
      phase_ff <= 2'h0;
    end else if (!pushValid_ff) begin
      qCnt_ff <= (qCnt_ff <= 6'h01) ? qLen : qCnt_ff - 6'h01;
      if (qTick) begin
        phase_ff <= phase_ff + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // transfer sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
      pinFunc_ff <= PIN_GPIO;
      pins_ff <= '{sclOe: 1'b0, sdaOe: 1'b0, sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      bitIdx_ff <= 3'h0;
      step_ff <= 2'h0;
      shOut_ff <= '0;
      shIn_ff <= '0;
      rxCount_ff <= '0;
      idPhase_ff <= 1'b1;
      isFlash_ff <= 1'b0;
      errEvent_ff <= 1'b0;
      done_ff <= 1'b0;
      push_ff <= '0;
      pushValid_ff <= 1'b0;
    end else if (hardRstSync) begin
      state_ff <= ST_IDLE;
      pinFunc_ff <= PIN_GPIO;
      pins_ff <= '{sclOe: 1'b0, sdaOe: 1'b0, sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      idPhase_ff <= 1'b1;
      isFlash_ff <= 1'b0;
      errEvent_ff <= 1'b0;
      done_ff <= 1'b0;
      pushValid_ff <= 1'b0;
    end else begin
      if (pushValid_ff && pushReady) begin
        pushValid_ff <= 1'b0;
      end
      case (state_ff)
        ST_IDLE: begin
          if (strapTaken_ff) begin
            state_ff <= ST_SEL;
          end
        end
        ST_SEL: begin
          // pins are switched one cycle before the first transfer starts
          step_ff <= 2'h0;
          bitIdx_ff <= 3'h0;
          rxCount_ff <= '0;
          case (src_ff)
            SRC_HOST: state_ff <= ST_HOST;
            SRC_I2C: begin
              pinFunc_ff <= PIN_I2C;
              shOut_ff <= `BIL_I2C_ADDR_WR;
              state_ff <= ST_START;
            end
            SRC_SPI_MAIN: begin
              pinFunc_ff <= PIN_SPI_MAIN;
              shOut_ff <= `BIL_SPI_IDENT;
              state_ff <= ST_START;
            end
            default: begin
              pinFunc_ff <= PIN_SPI_ALT;
              shOut_ff <= `BIL_SPI_IDENT;
              state_ff <= ST_START;
            end
          endcase
        end
        ST_HOST: begin
          done_ff <= 1'b1;
        end
        ST_START: begin
          if (qTick) begin
            if (isI2c) begin
              // release sda with scl low, raise scl, pull sda low, drop scl
              case (phase_ff)
                2'h0: pins_ff.sdaOe <= 1'b0;
                2'h1: pins_ff.sclOe <= 1'b0;
                2'h2: pins_ff.sdaOe <= 1'b1;
                default: pins_ff.sclOe <= 1'b1;
              endcase
            end else begin
              pins_ff.sck <= 1'b0;
              pins_ff.cs_n <= 1'b0;
            end
            if (phase_ff == 2'h3) begin
              state_ff <= ST_TX;
            end
          end
        end
        ST_TX, ST_RX: begin
          if (qTick) begin
            case (phase_ff)
              2'h0: begin
                if (state_ff == ST_TX) begin
                  pins_ff.mosi <= shOut_ff[7];
                  pins_ff.sdaOe <= isI2c && !shOut_ff[7];
                end else begin
                  pins_ff.sdaOe <= 1'b0;
                end
              end
              2'h1: begin
                pins_ff.sck <= !isI2c;
                pins_ff.sclOe <= 1'b0;
              end
              2'h2: shIn_ff <= rxByte;
              default: begin
                pins_ff.sck <= 1'b0;
                pins_ff.sclOe <= isI2c;
                shOut_ff <= {shOut_ff[6:0], 1'b0};
                bitIdx_ff <= bitIdx_ff + 3'h1;
              end
            endcase
          end
          if (byteEnd && state_ff == ST_TX) begin
            step_ff <= step_ff + 2'h1;
            if (isI2c) begin
              state_ff <= ST_ACK;
            end else if (idPhase_ff) begin
              state_ff <= ST_RX;
            end else begin
              shOut_ff <= 8'h00;
              state_ff <= (step_ff == 2'h3) ? ST_RX : ST_TX;
            end
          end else if (byteEnd) begin
            if (!isI2c && idPhase_ff) begin
              // blank reply means eeprom, capped at 4 Mbps; anything else is flash
              isFlash_ff <= (shIn_ff != `BIL_ID_BLANK_LO) && (shIn_ff != `BIL_ID_BLANK_HI);
              state_ff <= ST_STOP;
            end else if (rxCount_ff == 16'h0000 && shIn_ff != `BIL_IMG_MARKER) begin
              errEvent_ff <= 1'b1;
              state_ff <= ST_ERR;
            end else begin
              push_ff <= shIn_ff;
              pushValid_ff <= 1'b1;
              rxCount_ff <= rxCount_ff + 16'h0001;
              state_ff <= isI2c ? ST_ACK : (lastByte ? ST_STOP : ST_RX);
            end
          end
        end
        ST_ACK: begin
          if (qTick) begin
            case (phase_ff)
              2'h0: begin
                // master acks every image byte except the last one; while no byte
                // has arrived yet (read address included) the slot is the slave's
                pins_ff.sdaOe <= (rxCount_ff != 16'h0000) && (rxCount_ff != `BIL_IMG_BYTES);
              end
              2'h1: pins_ff.sclOe <= 1'b0;
              2'h2: begin
                if (rxCount_ff == 16'h0000 && sdaSync) begin
                  errEvent_ff <= 1'b1;
                  state_ff <= ST_ERR;
                end
              end
              default: begin
                pins_ff.sclOe <= 1'b1;
                pins_ff.sdaOe <= 1'b0;
                // step counts address bytes; it wraps to 0 once reading starts
                case (step_ff)
                  2'h0: state_ff <= (rxCount_ff == `BIL_IMG_BYTES) ? ST_STOP : ST_RX;
                  2'h3: begin
                    shOut_ff <= `BIL_I2C_ADDR_RD;
                    state_ff <= ST_START;
                  end
                  default: begin
                    shOut_ff <= 8'h00;
                    state_ff <= ST_TX;
                  end
                endcase
                if (step_ff == 2'h3) begin
                  step_ff <= 2'h3;
                end
              end
            endcase
          end
        end
        ST_STOP: begin
          if (qTick) begin
            if (isI2c) begin
              case (phase_ff)
                2'h0: pins_ff.sdaOe <= 1'b1;
                2'h1: pins_ff.sclOe <= 1'b0;
                2'h2: pins_ff.sdaOe <= 1'b0;
                default: pins_ff.sdaOe <= 1'b0;
              endcase
            end else begin
              pins_ff.cs_n <= 1'b1;
            end
            if (phase_ff == 2'h3) begin
              if (!isI2c && idPhase_ff) begin
                idPhase_ff <= 1'b0;
                step_ff <= 2'h0;
                shOut_ff <= `BIL_SPI_READ;
                state_ff <= ST_START;
              end else begin
                state_ff <= ST_DONE;
              end
            end
          end
        end
        ST_DONE: begin
          done_ff <= !pushValid_ff;
        end
        ST_ERR: begin
          pins_ff <= '{sclOe: 1'b0, sdaOe: 1'b0, sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
        end
        default: state_ff <= ST_IDLE;
      endcase
      if (state_ff == ST_RX && byteEnd == 1'b0 && cellEnd) begin
        step_ff <= 2'h0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // image buffer
  // ---------------------------------------------------------------------------
  bil_fifo #(
    .WIDTH(8),
    .DEPTH(`BIL_FIFO_DEPTH),
    .AW(`BIL_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .inData(push_ff),
    .inValid(pushValid_ff),
    .inReady(pushReady),
    .outData(imgData),
    .outValid(imgValid),
    .outReady(imgReady)
  );

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  // pll only allowed for host boot and the main spi pin set; i2c runs from the
  // bus clock (input clock / 2, 50 MHz at most) with the pll bypassed
  assign pllAllowed = (src_ff == SRC_HOST) || (src_ff == SRC_SPI_MAIN);
  assign hostBootEn = (state_ff == ST_HOST);
  assign pinFunc = pinFunc_ff;
  assign sclOut = 1'b0;
  assign sclOe = pins_ff.sclOe;
  assign sdaOut = 1'b0;
  assign sdaOe = pins_ff.sdaOe;
  assign spiSck = pins_ff.sck;
  assign spiCs_n = pins_ff.cs_n;
  assign spiMosi = pins_ff.mosi;
  assign spiFlash = isFlash_ff;
  assign bootDone = done_ff;
  assign bootErrEvent = errEvent_ff;

endmodule

// >>> hdl/bil_defines.svh
// boot image loader constants: strap fields, pin timing, transfer script
// assumes the loader runs on the 25 MHz peripheral bus clock (input clock / 2, pll bypassed)
`ifndef BIL_DEFINES_SVH
`define BIL_DEFINES_SVH

// -----------------------------------------------------------------------------
// clock and bit timing
// -----------------------------------------------------------------------------
`define BIL_CLK_NS 40
`define BIL_INCLK_MAX_MHZ 100
`define BIL_PBUS_MAX_MHZ 50
`define BIL_I2C_MAX_KBPS 400
`define BIL_I2C_DIV 128
`define BIL_I2C_QTR (`BIL_I2C_DIV / 4)
`define BIL_EEP_BIT_NS 250
`define BIL_EEP_QTR ((`BIL_EEP_BIT_NS + 4 * `BIL_CLK_NS - 1) / (4 * `BIL_CLK_NS))
`define BIL_FLASH_QTR 1

// -----------------------------------------------------------------------------
// strap vector field positions
// -----------------------------------------------------------------------------
`define BIL_STRAP_W 5
`define BIL_STRAP_WIDTH 0
`define BIL_STRAP_POL 1
`define BIL_STRAP_DUAL 2
`define BIL_STRAP_SRC_LO 3
`define BIL_STRAP_SRC_HI 4

// -----------------------------------------------------------------------------
// transfer script
// -----------------------------------------------------------------------------
`define BIL_I2C_ADDR_WR 8'hA0
`define BIL_I2C_ADDR_RD 8'hA1
`define BIL_SPI_IDENT 8'h9F
`define BIL_SPI_READ 8'h03
`define BIL_ID_BLANK_LO 8'h00
`define BIL_ID_BLANK_HI 8'hFF
`define BIL_IMG_MARKER 8'h5A
`define BIL_IMG_BYTES 16'h0400
`define BIL_FIFO_DEPTH 32
`define BIL_FIFO_AW 5

`endif

// >>> hdl/bil_pkg.sv
// boot image loader types shared by the loader and the bench
// assumes bil_defines.svh is on the include path
package bil_pkg;

  // boot source chosen by the source straps
  typedef enum logic [1:0] {
    SRC_HOST = 2'b00,
    SRC_I2C = 2'b01,
    SRC_SPI_MAIN = 2'b10,
    SRC_SPI_ALT = 2'b11
  } bil_src_t;

  // function given to the shared general-purpose pins
  typedef enum logic [1:0] {
    PIN_GPIO = 2'b00,
    PIN_I2C = 2'b01,
    PIN_SPI_MAIN = 2'b10,
    PIN_SPI_ALT = 2'b11
  } bil_pinfunc_t;

  // host parallel port configuration caught at power-on
  typedef struct packed {
    logic wide16;
    logic strobePolarity;
    logic dualStrobe;
  } bil_host_cfg_t;

  // serial pin drive, registered
  typedef struct packed {
    logic sclOe;
    logic sdaOe;
    logic sck;
    logic cs_n;
    logic mosi;
  } bil_pins_t;

endpackage

// >>> tb/bil_boot_loader_props.sv
// pin and status checker for the boot image loader
// assumes bil_pkg is compiled first; bound into every loader instance
`timescale 1ns/1ns
module bil_boot_loader_props
  import bil_pkg::*;
(
  // clock and resets
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hardRst_n,
  // observed outputs
  input wire bil_pinfunc_t pinFunc,
  input wire logic pllAllowed,
  input wire logic sclOe,
  input wire logic sdaOe,
  input wire logic spiSck,
  input wire logic spiCs_n,
  input wire logic spiFlash,
  input wire logic bootDone,
  input wire logic bootErrEvent
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic sclPrev_ff;
  logic [5:0] sclRun_ff;
  // -------------------------------------------------
  // cycles the clock line has stood, saturating
  // -------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclPrev_ff <= 1'b0;
      sclRun_ff <= 6'h00;
    end else begin
      sclPrev_ff <= sclOe;
      sclRun_ff <= (sclOe != sclPrev_ff) ? 6'h00 : sclRun_ff + {5'h00, ~&sclRun_ff};
    end
  end
  a_err_sticky: assert property (hardRst_n [*3] ##0 bootErrEvent |=> bootErrEvent)
    else $error("error event dropped");
  a_cs_idle: assert property (!pinFunc[1] |-> spiCs_n)
    else $error("select outside spi");
  a_i2c_pins: assert property ((sclOe || sdaOe) |-> pinFunc == PIN_I2C)
    else $error("i2c drive outside i2c");
  a_pll_i2c: assert property (pinFunc == PIN_I2C |-> !pllAllowed)
    else $error("pll in i2c boot");
  a_pll_alt: assert property (pinFunc == PIN_SPI_ALT |-> !pllAllowed)
    else $error("pll with alternate set");
  a_pll_main: assert property (pinFunc == PIN_SPI_MAIN |-> pllAllowed)
    else $error("pll barred with main set");
  // hard reset may cut a quarter short
  a_scl_quarter: assert property (disable iff (!arst_n || !hardRst_n)
    $fell(sclOe) |-> sclRun_ff >= 6'h1F) else $error("scl quarter short");
  a_sck_eeprom: assert property (disable iff (!arst_n || !hardRst_n)
    $fell(spiSck) && !spiFlash |-> $past(spiSck, 4)) else $error("sck too fast");
  a_sck_select: assert property (spiSck |-> !spiCs_n)
    else $error("sck without select");
  c_err: cover property ($rose(bootErrEvent));
  c_flash: cover property ($rose(spiFlash));
  c_done: cover property ($rose(bootDone));
endmodule
bind bil_boot_loader bil_boot_loader_props bil_boot_loader_props_i (.clk(clk),
  .arst_n(arst_n), .hardRst_n(hardRst_n), .pinFunc(pinFunc), .pllAllowed(pllAllowed),
  .sclOe(sclOe), .sdaOe(sdaOe), .spiSck(spiSck), .spiCs_n(spiCs_n), .spiFlash(spiFlash),
  .bootDone(bootDone), .bootErrEvent(bootErrEvent));

// >>> tb/bil_boot_loader_tb.sv
// self-checking bench for the boot image loader
// assumes the design, memory model and checker are compiled first
`timescale 1ns/1ns
`include "bil_defines.svh"
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: %s", $time, m); end end
module bil_boot_loader_tb
  import bil_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n, hardRst_n, imgReady, sdaIn, spiMiso, sclOe, sdaOe, spiSck, spiCs_n, spiMosi;
  logic imgValid, hostBootEn, pllAllowed, spiFlash, bootDone, bootErrEvent, sclOut, sdaOut;
  logic [4:0] strapPins;
  logic [7:0] imgData, idByte, marker;
  bil_host_cfg_t hostCfg;
  bil_pinfunc_t pinFunc;
  int mismatches, compares;
  always #20 clk = ~clk;
  // pull-up on the data line and no slave answering: every ack is a nack
  assign sdaIn = ~sdaOe;
  bil_boot_loader bil_boot_loader_i (.clk(clk), .arst_n(arst_n), .hardRst_n(hardRst_n),
    .strapPins(strapPins), .hostCfg(hostCfg), .hostBootEn(hostBootEn), .pinFunc(pinFunc),
    .pllAllowed(pllAllowed), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .sdaIn(sdaIn), .spiSck(spiSck), .spiCs_n(spiCs_n), .spiMosi(spiMosi), .spiMiso(spiMiso),
    .imgData(imgData), .imgValid(imgValid), .imgReady(imgReady), .spiFlash(spiFlash),
    .bootDone(bootDone), .bootErrEvent(bootErrEvent));
  bil_spi_mem bil_spi_mem_i (.sck(spiSck), .cs_n(spiCs_n), .mosi(spiMosi), .miso(spiMiso),
    .idByte(idByte), .marker(marker));
  task automatic test_done;
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic por(input logic [4:0] s);
    strapPins = s;
    arst_n = 1'b0;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  task automatic hrst;
    hardRst_n = 1'b0;
    repeat (5) @(negedge clk);
    hardRst_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  task automatic waitErr(input int n);
    for (int i = 0; i < n && bootErrEvent !== 1'b1; i++) @(negedge clk);
  endtask
  task automatic sclRise(output int t);
    t = 0;
    while (sclOe !== 1'b1 && t < 300) begin @(negedge clk); t++; end
    while (sclOe !== 1'b0 && t < 300) begin @(negedge clk); t++; end
  endtask
  task automatic hostBoot;
    por(5'h05);
    `CHK(hostCfg, 3'h5, "host config")
    `CHK(hostBootEn, 1'b1, "host source")
    strapPins = 5'h0A;
    hrst;
    `CHK(hostCfg, 3'h5, "config kept")
    `CHK(hostBootEn, 1'b1, "source kept")
    por(5'h02);
    `CHK(hostCfg, 3'h2, "config retaken")
  endtask
  task automatic i2cNack;
    int t;
    logic [7:0] b;
    por(5'h08);
    `CHK(pinFunc, PIN_I2C, "i2c pins")
    `CHK(pllAllowed, 1'b0, "pll in i2c")
    for (int i = 0; i < 8; i++) begin
      sclRise(t);
      b = {b[6:0], ~sdaOe};
      if (i > 0) `CHK(t, 128, "bit period")
    end
    `CHK(b, 8'hA0, "slave address")
    `CHK({sclOut, sdaOut}, 2'h0, "open drain low")
    waitErr(400);
    `CHK(bootErrEvent, 1'b1, "nack error")
    repeat (50) @(negedge clk);
    `CHK(bootErrEvent, 1'b1, "error held")
    hrst;
    `CHK(bootErrEvent, 1'b0, "error cleared")
  endtask
  task automatic eepromBad(input logic [7:0] id);
    idByte = id;
    marker = 8'h33;
    por(5'h18);
    `CHK(pinFunc, PIN_SPI_ALT, "alt pins")
    `CHK(pllAllowed, 1'b0, "pll with alt")
    waitErr(3000);
    `CHK(spiFlash, 1'b0, "eeprom kind")
    `CHK(bootErrEvent, 1'b1, "marker error")
  endtask
  task automatic flashBoot;
    int n;
    logic s;
    idByte = 8'h20;
    marker = `BIL_IMG_MARKER;
    por(5'h10);
    `CHK(pinFunc, PIN_SPI_MAIN, "main pins")
    `CHK(pllAllowed, 1'b1, "pll with main")
    repeat (3000) @(negedge clk);
    s = spiSck;
    n = 0;
    repeat (200) begin @(negedge clk); n += int'(spiSck !== s); s = spiSck; end
    `CHK(n, 0, "full buffer stalls fetch")
    n = 0;
    for (int i = 0; i < 40000 && n < `BIL_IMG_BYTES; i++) begin
      imgReady = (i % 5 != 0);
      if (imgValid === 1'b1 && imgReady) begin
        `CHK(imgData, (n == 0) ? `BIL_IMG_MARKER : 8'(n), "image byte")
        n++;
      end
      @(negedge clk);
    end
    imgReady = 1'b0;
    repeat (20) @(negedge clk);
    `CHK(n, `BIL_IMG_BYTES, "image length")
    `CHK(imgValid, 1'b0, "buffer empty")
    `CHK(spiFlash, 1'b1, "flash kind")
    `CHK(bootDone, 1'b1, "boot done")
    `CHK(bil_spi_mem_i.cmd, `BIL_SPI_READ, "read command")
    `CHK(bootErrEvent, 1'b0, "no error")
  endtask
  initial begin
    arst_n = 1'b0;
    hardRst_n = 1'b1;
    imgReady = 1'b0;
    idByte = 8'h00;
    marker = 8'h00;
    mismatches = 0;
    compares = 0;
    hostBoot;
    i2cNack;
    eepromBad(8'h00);
    eepromBad(8'hFF);
    flashBoot;
    test_done;
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    test_done;
  end
endmodule

// >>> tb/bil_spi_mem.sv
// serial boot memory model: identification and read commands, mode 0
// assumes the master keeps its clock still between frames
`timescale 1ns/1ns
`include "bil_defines.svh"
module bil_spi_mem (
  // serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  // reply set by the bench
  input wire logic [7:0] idByte,
  input wire logic [7:0] marker
);
  logic [7:0] cmd;
  logic [7:0] cur;
  logic heldBit = 1'b0;
  int inCnt;
  int outCnt;
  always @(negedge cs_n) begin
    inCnt = 0;
    outCnt = 0;
  end
  always @(posedge sck) if (!cs_n && inCnt < 8) begin
    cmd = {cmd[6:0], mosi};
    inCnt++;
  end
  // slave only: next bit leaves on the master's falling clock
  always @(negedge sck) if (!cs_n) outCnt++;
  always @(posedge cs_n) heldBit = cur[7 - outCnt % 8];
  always @* begin
    if (cmd == `BIL_SPI_IDENT) cur = idByte;
    else if (outCnt / 8 == 4) cur = marker;
    else cur = 8'(outCnt / 8 - 4);
    // released line shows the inverse, so a stale sample cannot match
    miso = cs_n ? ~heldBit : cur[7 - outCnt % 8];
  end
endmodule
